// *** src/dmrc_pkg.sv ***
// Constants, register map and types for the drive mode and ramp controller
package dmrc_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int          ADDR_W     = 8;
    localparam logic [7:0]  A_CTRL     = 8'h00;
    localparam logic [7:0]  A_MIN_FREQ = 8'h04;
    localparam logic [7:0]  A_MAX_FREQ = 8'h08;
    localparam logic [7:0]  A_ACC_TIME = 8'h0c;
    localparam logic [7:0]  A_DEC_TIME = 8'h10;
    localparam logic [7:0]  A_STATUS   = 8'h14;
    localparam logic [7:0]  A_FREQ     = 8'h18;
    localparam logic [7:0]  A_TARGET   = 8'h1c;

    // ------------------------------------------------------------------
    // Control and status fields
    // ------------------------------------------------------------------
    localparam int B_SCHEME    = 0;
    localparam int B_FREEWHEEL = 3;
    localparam int B_GUARD     = 4;
    localparam int B_FN1       = 5;
    localparam int B_FN2       = 7;
    localparam int B_PRECHARGE = 9;
    localparam int B_LEADLAG   = 10;
    localparam int B_FAULT     = 0;
    localparam int B_DRIVE     = 1;
    localparam int B_BACKUP    = 2;
    localparam int B_STATE     = 3;

    // ------------------------------------------------------------------
    // Schemes and contact functions
    // ------------------------------------------------------------------
    localparam logic [2:0] SCH_CONTACT  = 3'h0;
    localparam logic [2:0] SCH_PRESSURE = 3'h1;
    localparam logic [2:0] SCH_VOLT     = 3'h2;
    localparam logic [2:0] SCH_LOOP     = 3'h3;
    localparam logic [1:0] FN_ALWAYS    = 2'h0;
    localparam logic [1:0] FN_CLOSED    = 2'h1;
    localparam logic [1:0] FN_OPEN      = 2'h2;

    // ------------------------------------------------------------------
    // Reset values, frequencies in 0.1 Hz, times in 0.1 s
    // ------------------------------------------------------------------
    localparam logic        RST_FREEWHEEL = 1'b1;
    localparam logic        RST_GUARD     = 1'b1;
    localparam logic [15:0] RST_MIN_FREQ  = 16'h012c;
    localparam logic [15:0] MIN_FREQ_FLOOR = 16'h0032;
    localparam logic [15:0] RST_MAX_FREQ  = 16'h0258;
    localparam logic [15:0] RST_ACC_TIME  = 16'h0064;
    localparam logic [15:0] RST_DEC_TIME  = 16'h0028;

    // ------------------------------------------------------------------
    // Analog scaling
    // ------------------------------------------------------------------
    localparam logic [15:0] LOOP_ZERO_UA = 16'h0fa0;
    localparam logic [15:0] LOOP_FULL_UA = 16'h4e20;
    localparam logic [31:0] LOOP_SPAN_UA = 32'h00003e80;
    localparam logic [15:0] LOOP_LOST_UA = 16'h01f4;
    localparam int          VOLT_W       = 12;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_NS       = 10000;
    localparam int TICK_CYC      = TICK_NS / CLK_PERIOD_NS;
    localparam int STEP_NS       = 100000000;
    localparam int TICKS_PER_DS  = STEP_NS / TICK_NS;
    localparam int GUARD_NS      = 1000000000;
    localparam int GUARD_TICKS   = GUARD_NS / TICK_NS;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ACCEL,
        ST_HOLD,
        ST_DECEL
    } dmrc_state_type;

endpackage : dmrc_pkg

// *** src/dmrc_top.sv ***
// Control scheme selection and output frequency ramp generator
//
// How it works
// - Scheme 0 runs motor from contacts
// - Contacts default to permanent run request
// - Scheme 1 holds pressure from primary loop
// - Primary loop below 500 uA selects backup loop
// - Both loops lost stops, raises fault
// - Scheme 2 follows 0-5 V potentiometer
// - Scheme 3 follows 4-20 mA loop
// - Ignore analog below lowest speed setting
// - Loop speed is linear, unregulated
// - Precharge, lead/lag only in pressure scheme
// - Ramp times span lowest to top speed
// - Accel 10 s, decel 4 s reset
// - Freewheel halt default, drops drive instantly
// - Guard limits start below lowest speed
// - Guard reaches lowest speed in 1 s
// - Guard off gives single linear ramp
// - Upper segment uses configured accel time
//
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps

module dmrc_top #(
    parameter int TICK_CYC     = dmrc_pkg::TICK_CYC,
    parameter int TICKS_PER_DS = dmrc_pkg::TICKS_PER_DS,
    parameter int GUARD_TICKS  = dmrc_pkg::GUARD_TICKS
) (
    input  wire logic        clk_sys_i,
    input  wire logic        rst_n_i,
    input  wire logic [7:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [31:0] rdata_o,
    input  wire logic        first_remote_contact_i,
    input  wire logic        second_remote_contact_i,
    input  wire logic [15:0] loop1_ua_i,
    input  wire logic [15:0] loop2_ua_i,
    input  wire logic [11:0] volt_code_i,
    input  wire logic [15:0] pressure_speed_req_i,
    output logic      [15:0] output_freq_o,
    output logic             drive_on_o,
    output logic      [15:0] feedback_ua_o,
    output logic             backup_sel_o,
    output logic             sensor_fault_o,
    output logic             precharge_en_o,
    output logic             lead_lag_en_o
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic                     c1_meta;
        logic                     c1;
        logic                     c2_meta;
        logic                     c2;
        logic [2:0]               scheme;
        logic                     freewheel;
        logic                     guard;
        logic [1:0]               fn1;
        logic [1:0]               fn2;
        logic                     pre_req;
        logic                     ll_req;
        logic [15:0]              min_f;
        logic [15:0]              max_f;
        logic [15:0]              acc_t;
        logic [15:0]              dec_t;
        logic                     fault;
        logic                     use_bk;
        logic [15:0]              fb;
        logic                     pre_en;
        logic                     ll_en;
        logic [15:0]              tgt;
        logic                     run_ok;
        logic [15:0]              freq;
        logic                     drive;
        logic [31:0]              acc;
        logic [15:0]              tick;
        dmrc_pkg::dmrc_state_type state;
        logic [31:0]              rdata;
    } dmrc_regs_type;

    dmrc_regs_type s_q;
    dmrc_regs_type s_d;
    logic [1:0]    rst_sync_q;
    logic          rst_n;

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    function automatic logic contact_ok(input logic [1:0] fn, input logic closed);
        logic r;
        unique case (fn)
            dmrc_pkg::FN_ALWAYS: r = 1'b1;
            dmrc_pkg::FN_OPEN:   r = !closed;
            default:             r = closed;
        endcase
        return r;
    endfunction : contact_ok

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    logic        ok_both;
    logic        lost1;
    logic        lost2;
    logic [31:0] mapped;
    logic [15:0] ua;
    logic [15:0] span;
    logic [31:0] per;
    logic [31:0] acc_n;
    logic [15:0] goal;
    logic        tick_hit;

    always_comb begin
        s_d      = s_q;
        mapped   = 32'h0;
        tick_hit = 1'b0;

        s_d.c1_meta = first_remote_contact_i;
        s_d.c1      = s_q.c1_meta;
        s_d.c2_meta = second_remote_contact_i;
        s_d.c2      = s_q.c2_meta;

        // Register writes
        if (wr_i) begin
            case (addr_i)
                dmrc_pkg::A_CTRL: begin
                    if (wdata_i[dmrc_pkg::B_SCHEME +: 3] <= dmrc_pkg::SCH_LOOP) begin
                        s_d.scheme = wdata_i[dmrc_pkg::B_SCHEME +: 3];
                    end
                    s_d.freewheel = wdata_i[dmrc_pkg::B_FREEWHEEL];
                    s_d.guard     = wdata_i[dmrc_pkg::B_GUARD];
                    s_d.fn1       = wdata_i[dmrc_pkg::B_FN1 +: 2];
                    s_d.fn2       = wdata_i[dmrc_pkg::B_FN2 +: 2];
                    s_d.pre_req   = wdata_i[dmrc_pkg::B_PRECHARGE];
                    s_d.ll_req    = wdata_i[dmrc_pkg::B_LEADLAG];
                end
                dmrc_pkg::A_MIN_FREQ: begin
                    if (wdata_i[15:0] < dmrc_pkg::MIN_FREQ_FLOOR) begin
                        s_d.min_f = dmrc_pkg::MIN_FREQ_FLOOR;
                    end else begin
                        s_d.min_f = wdata_i[15:0];
                    end
                end
                dmrc_pkg::A_MAX_FREQ: begin
                    s_d.max_f = wdata_i[15:0];
                end
                dmrc_pkg::A_ACC_TIME: begin
                    s_d.acc_t = wdata_i[15:0];
                end
                dmrc_pkg::A_DEC_TIME: begin
                    s_d.dec_t = wdata_i[15:0];
                end
                dmrc_pkg::A_STATUS: begin
                    if (wdata_i[dmrc_pkg::B_FAULT]) begin
                        s_d.fault = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end

        // Register reads
        s_d.rdata = 32'h0;
        if (rd_i) begin
            case (addr_i)
                dmrc_pkg::A_CTRL: begin
                    s_d.rdata[dmrc_pkg::B_SCHEME +: 3]  = s_q.scheme;
                    s_d.rdata[dmrc_pkg::B_FREEWHEEL]    = s_q.freewheel;
                    s_d.rdata[dmrc_pkg::B_GUARD]        = s_q.guard;
                    s_d.rdata[dmrc_pkg::B_FN1 +: 2]     = s_q.fn1;
                    s_d.rdata[dmrc_pkg::B_FN2 +: 2]     = s_q.fn2;
                    s_d.rdata[dmrc_pkg::B_PRECHARGE]    = s_q.pre_req;
                    s_d.rdata[dmrc_pkg::B_LEADLAG]      = s_q.ll_req;
                end
                dmrc_pkg::A_MIN_FREQ: s_d.rdata[15:0] = s_q.min_f;
                dmrc_pkg::A_MAX_FREQ: s_d.rdata[15:0] = s_q.max_f;
                dmrc_pkg::A_ACC_TIME: s_d.rdata[15:0] = s_q.acc_t;
                dmrc_pkg::A_DEC_TIME: s_d.rdata[15:0] = s_q.dec_t;
                dmrc_pkg::A_STATUS: begin
                    s_d.rdata[dmrc_pkg::B_FAULT]      = s_q.fault;
                    s_d.rdata[dmrc_pkg::B_DRIVE]      = s_q.drive;
                    s_d.rdata[dmrc_pkg::B_BACKUP]     = s_q.use_bk;
                    s_d.rdata[dmrc_pkg::B_STATE +: 2] = s_q.state;
                end
                dmrc_pkg::A_FREQ:   s_d.rdata[15:0] = s_q.freq;
                dmrc_pkg::A_TARGET: s_d.rdata[15:0] = s_q.tgt;
                default: begin
                end
            endcase
        end

        // --------------------------------------------------------------
        // Contacts and sensors
        // --------------------------------------------------------------
        // contact function gating
        ok_both = contact_ok(s_q.fn1, s_q.c1) && contact_ok(s_q.fn2, s_q.c2);
        lost1   = loop1_ua_i < dmrc_pkg::LOOP_LOST_UA;
        lost2   = loop2_ua_i < dmrc_pkg::LOOP_LOST_UA;
        s_d.use_bk = lost1;
        s_d.fb     = lost1 ? loop2_ua_i : loop1_ua_i;
        if (s_q.scheme == dmrc_pkg::SCH_PRESSURE && lost1 && lost2) begin
            s_d.fault = 1'b1;
        end
        s_d.pre_en = s_q.pre_req && (s_q.scheme == dmrc_pkg::SCH_PRESSURE);
        s_d.ll_en  = s_q.ll_req && (s_q.scheme == dmrc_pkg::SCH_PRESSURE);

        // --------------------------------------------------------------
        // Target selection
        // --------------------------------------------------------------
        ua = loop1_ua_i;
        if (ua > dmrc_pkg::LOOP_FULL_UA) begin
            ua = dmrc_pkg::LOOP_FULL_UA;
        end
        if (ua < dmrc_pkg::LOOP_ZERO_UA) begin
            ua = dmrc_pkg::LOOP_ZERO_UA;
        end
        unique case (s_q.scheme)
            dmrc_pkg::SCH_CONTACT: begin
                s_d.tgt    = s_q.max_f;
                s_d.run_ok = ok_both;
            end
            dmrc_pkg::SCH_PRESSURE: begin
                s_d.tgt = pressure_speed_req_i;
                if (pressure_speed_req_i < s_q.min_f) begin
                    s_d.tgt = s_q.min_f;
                end
                if (pressure_speed_req_i > s_q.max_f) begin
                    s_d.tgt = s_q.max_f;
                end
                s_d.run_ok = ok_both && !s_q.fault;
            end
            dmrc_pkg::SCH_VOLT: begin
                mapped     = ({20'h0, volt_code_i} * {16'h0, s_q.max_f}) >> dmrc_pkg::VOLT_W;
                s_d.tgt    = mapped[15:0];
                s_d.run_ok = ok_both && (mapped[15:0] >= s_q.min_f);
            end
            default: begin
                mapped     = ({16'h0, ua - dmrc_pkg::LOOP_ZERO_UA} * {16'h0, s_q.max_f})
                             / dmrc_pkg::LOOP_SPAN_UA;
                s_d.tgt    = mapped[15:0];
                s_d.run_ok = ok_both && (mapped[15:0] >= s_q.min_f);
            end
        endcase

        // --------------------------------------------------------------
        // Ramp generator
        // --------------------------------------------------------------
        // fixed tick rate
        if (s_q.tick == 16'(TICK_CYC - 1)) begin
            s_d.tick = 16'h0;
            tick_hit = 1'b1;
        end else begin
            s_d.tick = s_q.tick + 16'h1;
        end
        goal = s_q.run_ok ? s_q.tgt : 16'h0;
        span = (s_q.max_f > s_q.min_f) ? (s_q.max_f - s_q.min_f) : 16'h1;
        if (s_q.freq < goal) begin
            if (s_q.guard && s_q.freq < s_q.min_f) begin
                span = s_q.min_f;
                per  = 32'(GUARD_TICKS);
            end else begin
                per = {16'h0, s_q.acc_t} * 32'(TICKS_PER_DS);
            end
        end else begin
            per = {16'h0, s_q.dec_t} * 32'(TICKS_PER_DS);
        end
        if (per == 32'h0) begin
            per = 32'h1;
        end
        acc_n = s_q.acc + {16'h0, span};
        if (!s_q.run_ok && s_q.freewheel) begin
            s_d.freq = 16'h0;
            s_d.acc  = 32'h0;
        end else if (s_q.freq == goal) begin
            s_d.acc = 32'h0;
        end else if (tick_hit) begin
            if (acc_n >= per) begin
                s_d.acc  = acc_n - per;
                s_d.freq = (s_q.freq < goal) ? s_q.freq + 16'h1 : s_q.freq - 16'h1;
            end else begin
                s_d.acc = acc_n;
            end
        end
        s_d.drive = (s_d.freq != 16'h0);
        if (s_d.freq == 16'h0 && goal == 16'h0) begin
            s_d.state = dmrc_pkg::ST_IDLE;
        end else if (s_d.freq < goal) begin
            s_d.state = dmrc_pkg::ST_ACCEL;
        end else if (s_d.freq > goal) begin
            s_d.state = dmrc_pkg::ST_DECEL;
        end else begin
            s_d.state = dmrc_pkg::ST_HOLD;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            s_q           <= '0;
            s_q.scheme    <= dmrc_pkg::SCH_CONTACT;
            s_q.fn1       <= dmrc_pkg::FN_ALWAYS;
            s_q.fn2       <= dmrc_pkg::FN_ALWAYS;
            s_q.freewheel <= dmrc_pkg::RST_FREEWHEEL;
            s_q.guard     <= dmrc_pkg::RST_GUARD;
            s_q.min_f     <= dmrc_pkg::RST_MIN_FREQ;
            s_q.max_f     <= dmrc_pkg::RST_MAX_FREQ;
            s_q.acc_t     <= dmrc_pkg::RST_ACC_TIME;
            s_q.dec_t     <= dmrc_pkg::RST_DEC_TIME;
            s_q.state     <= dmrc_pkg::ST_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign rdata_o        = s_q.rdata;
    assign output_freq_o  = s_q.freq;
    assign drive_on_o     = s_q.drive;
    assign feedback_ua_o  = s_q.fb;
    assign backup_sel_o   = s_q.use_bk;
    assign sensor_fault_o = s_q.fault;
    assign precharge_en_o = s_q.pre_en;
    assign lead_lag_en_o  = s_q.ll_en;

endmodule : dmrc_top

// *** testbench/dmrc_assertions.sv ***
// Port-level assertions for the drive mode and ramp controller
`timescale 1ns/1ps
module dmrc_checker #(
    parameter int TICK_CYC = 4
) (
    input wire logic        clk_sys_i,
    input wire logic        rst_n_i,
    input wire logic [7:0]  addr_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    input wire logic [31:0] rdata_o,
    input wire logic [15:0] loop1_ua_i,
    input wire logic [15:0] loop2_ua_i,
    input wire logic [15:0] output_freq_o,
    input wire logic        drive_on_o,
    input wire logic [15:0] feedback_ua_o,
    input wire logic        sensor_fault_o,
    input wire logic        precharge_en_o,
    input wire logic        lead_lag_en_o
);
    // --------
    // Helper state
    // --------
    logic [2:0]  live_q;
    logic [15:0] gap_q;
    logic [15:0] prev_q;
    wire         live   = live_q[2];
    wire         ctl_wr = wr_i && addr_i == dmrc_pkg::A_CTRL;
    wire         lost   = loop1_ua_i < dmrc_pkg::LOOP_LOST_UA &&
                          loop2_ua_i < dmrc_pkg::LOOP_LOST_UA;
    wire         step   = live && output_freq_o != prev_q &&
                          output_freq_o != 16'h0 && prev_q != 16'h0;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            live_q <= 3'h0;
            gap_q  <= 16'h0;
            prev_q <= 16'h0;
        end else begin
            live_q <= live_q[2] ? live_q : live_q + 3'h1;
            gap_q  <= (output_freq_o != prev_q) ? 16'h0 : gap_q + {15'h0, ~&gap_q};
            prev_q <= output_freq_o;
        end
    end

    // --------
    // Properties
    // --------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_unmapped_rd;
        rd_i && addr_i > dmrc_pkg::A_TARGET;
    endsequence
    property p_step;
        step |-> output_freq_o == prev_q + 16'h1 || output_freq_o + 16'h1 == prev_q;
    endproperty
    property p_tick;
        step |-> gap_q >= 16'(TICK_CYC - 1);
    endproperty
    property p_drive;
        drive_on_o == (output_freq_o != 16'h0);
    endproperty
    property p_fault;
        $rose(sensor_fault_o) |-> $past(lost) || $past(lost, 2);
    endproperty
    property p_feedback;
        live |-> feedback_ua_o == (($past(loop1_ua_i) < dmrc_pkg::LOOP_LOST_UA) ?
                                   $past(loop2_ua_i) : $past(loop1_ua_i));
    endproperty
    property p_pre;
        $rose(precharge_en_o) |-> $past(ctl_wr) || $past(ctl_wr, 2) || $past(ctl_wr, 3);
    endproperty
    property p_lead;
        $rose(lead_lag_en_o) |-> $past(ctl_wr) || $past(ctl_wr, 2) || $past(ctl_wr, 3);
    endproperty
    property p_unmapped;
        s_unmapped_rd |=> rdata_o == 32'h0;
    endproperty

    a_step: assert property (p_step) else $error("frequency jumped");
    a_tick: assert property (p_tick) else $error("steps too close");
    a_drive: assert property (p_drive) else $error("drive flag off");
    a_fault: assert property (p_fault) else $error("fault without loss");
    a_feedback: assert property (p_feedback) else $error("feedback source");
    a_pre: assert property (p_pre) else $error("precharge rose alone");
    a_lead: assert property (p_lead) else $error("lead lag rose alone");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read");
endmodule : dmrc_checker

bind dmrc_top dmrc_checker #(.TICK_CYC(TICK_CYC)) u_dmrc_chk (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .loop1_ua_i(loop1_ua_i), .loop2_ua_i(loop2_ua_i),
    .output_freq_o(output_freq_o), .drive_on_o(drive_on_o),
    .feedback_ua_o(feedback_ua_o), .sensor_fault_o(sensor_fault_o),
    .precharge_en_o(precharge_en_o), .lead_lag_en_o(lead_lag_en_o)
);

// *** testbench/dmrc_field_model.sv ***
// Field side: remote contacts, loop transducers, potentiometer, regulator
`timescale 1ns/1ps
module dmrc_field_model (
    input  wire logic        clk_sys_i,
    input  wire logic        c1_i,
    input  wire logic        c2_i,
    input  wire logic [15:0] l1_i,
    input  wire logic [15:0] l2_i,
    input  wire logic [11:0] v_i,
    input  wire logic [15:0] p_i,
    output logic             first_remote_contact_o,
    output logic             second_remote_contact_o,
    output logic      [15:0] loop1_ua_o,
    output logic      [15:0] loop2_ua_o,
    output logic      [11:0] volt_code_o,
    output logic      [15:0] pressure_speed_req_o
);
    // --------
    // Switches and transducers
    // --------
    always @(posedge clk_sys_i) begin
        first_remote_contact_o  <= c1_i;
        second_remote_contact_o <= c2_i;
        loop1_ua_o              <= l1_i;
        loop2_ua_o              <= l2_i;
        volt_code_o             <= v_i;
        pressure_speed_req_o    <= p_i;
    end
endmodule : dmrc_field_model

// *** testbench/dmrc_top_tb.sv ***
// Self-checking bench for the drive mode and ramp controller
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((e) !== (g)) begin n_errors++; \
    $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module dmrc_top_tb;
    logic        clk_sys_i = 1'b0;
    logic        rst_n_i   = 1'b0;
    logic [7:0]  addr_i    = 8'h00;
    logic [31:0] wdata_i   = 32'h0;
    logic        wr_i      = 1'b0;
    logic        rd_i      = 1'b0;
    logic        rd_seen   = 1'b0;
    logic        c1        = 1'b0;
    logic        c2        = 1'b0;
    logic [15:0] l1        = 16'h2710;
    logic [15:0] l2        = 16'h1f40;
    logic [11:0] v         = 12'h0;
    logic [15:0] p         = 16'h0;
    logic [11:0] rv;
    logic [15:0] ru, rp;
    logic [31:0] exp_v;
    logic [31:0] exp_q[$];
    int          n_errors  = 0;
    int          compares  = 0;
    int          seed      = 32'ha37feecf;
    int          n;
    wire  [31:0] rdata;
    wire  [15:0] lu1, lu2, preq, freq, fb;
    wire  [11:0] vc;
    wire         fc1, fc2, drv, bsel, flt, pre, ll;

    dmrc_field_model u_field (
        .clk_sys_i(clk_sys_i), .c1_i(c1), .c2_i(c2), .l1_i(l1), .l2_i(l2), .v_i(v), .p_i(p),
        .first_remote_contact_o(fc1), .second_remote_contact_o(fc2), .loop1_ua_o(lu1),
        .loop2_ua_o(lu2), .volt_code_o(vc), .pressure_speed_req_o(preq)
    );
    dmrc_top #(.TICK_CYC(2), .TICKS_PER_DS(10), .GUARD_TICKS(100)) dut (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata), .first_remote_contact_i(fc1),
        .second_remote_contact_i(fc2), .loop1_ua_i(lu1), .loop2_ua_i(lu2),
        .volt_code_i(vc), .pressure_speed_req_i(preq), .output_freq_o(freq),
        .drive_on_o(drv), .feedback_ua_o(fb), .backup_sel_o(bsel),
        .sensor_fault_o(flt), .precharge_en_o(pre), .lead_lag_en_o(ll)
    );

    always #5 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) rd_seen <= rd_i;
    always @(negedge clk_sys_i) begin
        if (rd_seen) begin
            exp_v = exp_q.pop_front();
            `CHK("rdata", exp_v, rdata)
        end
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_sys_i);
        wr_i    <= 1'b0;
        @(posedge clk_sys_i);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_sys_i);
        rd_i   <= 1'b0;
        @(posedge clk_sys_i);
    endtask : rd
    task automatic wait_freq(input logic [15:0] f);
        n = 0;
        while (freq !== f && n < 6000) begin
            @(posedge clk_sys_i);
            n++;
        end
    endtask : wait_freq
    task automatic near(input int e);
        `CHK("ramp time", 1'b1, n > e - 8 && n < e + 16)
    endtask : near
    task automatic ramp(input int t1, input int t2);
        c1 <= 1'b1;
        wait_freq(16'h3c);
        near(t1);
        wait_freq(16'h78);
        near(t2);
    endtask : ramp
    function automatic logic [31:0] tgt(input int s, input logic [11:0] cv,
                                        input logic [15:0] cu, input logic [15:0] cp);
        logic [31:0] u;
        u = (cu > 16'h4e20) ? 32'h4e20 : {16'h0, cu};
        case (s)
            0: return 32'h78;
            1: return (cp < 16'h3c) ? 32'h3c : (cp > 16'h78) ? 32'h78 : {16'h0, cp};
            2: return ({20'h0, cv} * 32'h78) >> 12;
            default: return (u - 32'hfa0) * 32'h78 / 32'h3e80;
        endcase
    endfunction : tgt
    task automatic tally_and_finish;
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        #200000;
        n_errors++;
        tally_and_finish();
    end
    initial begin
        repeat (16) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        repeat (12) @(posedge clk_sys_i);
        `CHK("run open", 1'b1, drv)
        rd(dmrc_pkg::A_CTRL, 32'h18);
        rd(dmrc_pkg::A_MIN_FREQ, 32'h12c);
        rd(dmrc_pkg::A_MAX_FREQ, 32'h258);
        rd(dmrc_pkg::A_ACC_TIME, 32'h64);
        rd(dmrc_pkg::A_DEC_TIME, 32'h28);
        rd(8'h20, 32'h0);
        wr(dmrc_pkg::A_CTRL, 32'h38);
        repeat (8) @(posedge clk_sys_i);
        `CHK("stopped", 16'h0, freq)
        wr(dmrc_pkg::A_MIN_FREQ, 32'h10);
        rd(dmrc_pkg::A_MIN_FREQ, 32'h32);
        wr(dmrc_pkg::A_MIN_FREQ, 32'h3c);
        wr(dmrc_pkg::A_MAX_FREQ, 32'h78);
        wr(dmrc_pkg::A_ACC_TIME, 32'h14);
        ramp(200, 400);
        c1 <= 1'b0;
        repeat (8) @(posedge clk_sys_i);
        `CHK("coast", 16'h0, freq)
        wr(dmrc_pkg::A_CTRL, 32'h20);
        ramp(400, 400);
        c1 <= 1'b0;
        wait_freq(16'h0);
        near(1600);
        for (int i = 0; i < 16; i++) begin
            rv = 12'($random(seed));
            ru = 16'h0fa0 + 16'($unsigned($random(seed)) % 17000);
            rp = 16'($unsigned($random(seed)) % 200);
            v  <= rv;
            l1 <= ru;
            p  <= rp;
            wr(dmrc_pkg::A_CTRL, 32'h0a8 + 32'(i % 4));
            repeat (4) @(posedge clk_sys_i);
            rd(dmrc_pkg::A_TARGET, tgt(i % 4, rv, ru, rp));
        end
        wr(dmrc_pkg::A_CTRL, 32'h0ab);
        l1 <= 16'h1770;
        c1 <= 1'b1;
        c2 <= 1'b1;
        repeat (12) @(posedge clk_sys_i);
        `CHK("below min", 1'b0, drv)
        l1 <= 16'h4e20;
        c2 <= 1'b0;
        repeat (12) @(posedge clk_sys_i);
        `CHK("one contact", 1'b0, drv)
        c2 <= 1'b1;
        repeat (16) @(posedge clk_sys_i);
        `CHK("both contacts", 1'b1, drv)
        wr(dmrc_pkg::A_CTRL, 32'h609);
        l1 <= 16'h2710;
        p  <= 16'h50;
        repeat (6) @(posedge clk_sys_i);
        `CHK("precharge", 1'b1, pre)
        `CHK("lead lag", 1'b1, ll)
        `CHK("feedback", 16'h2710, fb)
        l1 <= 16'h0;
        repeat (4) @(posedge clk_sys_i);
        `CHK("feedback", 16'h1f40, fb)
        `CHK("backup", 1'b1, bsel)
        l2 <= 16'h0;
        repeat (12) @(posedge clk_sys_i);
        `CHK("fault", 1'b1, flt)
        `CHK("fault stop", 1'b0, drv)
        rd(dmrc_pkg::A_STATUS, 32'h5);
        wr(dmrc_pkg::A_CTRL, 32'h60b);
        repeat (4) @(posedge clk_sys_i);
        `CHK("precharge", 1'b0, pre)
        wr(dmrc_pkg::A_STATUS, 32'h1);
        rd(dmrc_pkg::A_STATUS, 32'h4);
        wr(dmrc_pkg::A_CTRL, 32'h00d);
        rd(dmrc_pkg::A_CTRL, 32'h00b);
        tally_and_finish();
    end
endmodule : dmrc_top_tb
